/* File: hw/arts_defines.vh */
`ifndef ARTS_DEFINES_VH
`define ARTS_DEFINES_VH
// ****************************************
// register map, page f
// ****************************************
`define ARTS_PAGE 4'hf
`define ARTS_ADDR_CTRL 8'hc8
`define ARTS_ADDR_RLD_LO 8'hca
`define ARTS_ADDR_RLD_HI 8'hcb
`define ARTS_ADDR_CNT_LO 8'hcc
`define ARTS_ADDR_CNT_HI 8'hcd
// ****************************************
// control field positions
// ****************************************
`define ARTS_BIT_HIGH_OVF 7
`define ARTS_BIT_LOW_OVF 6
`define ARTS_BIT_LOW_IRQ_EN 5
`define ARTS_BIT_SPLIT 3
`define ARTS_BIT_RUN 2
`define ARTS_BIT_EXT_SEL 0
// writable bits; positions 4 and 1 are unused and read zero
`define ARTS_CTRL_MASK 8'hed
`define ARTS_RESET_BYTE 8'h00
`define ARTS_BYTE_ONES 8'hff
`define ARTS_WORD_ONES 16'hffff
// ****************************************
// prescaler figures
// ****************************************
`define ARTS_SYS_DIV 12
`define ARTS_EXT_DIV 8
`endif

/* File: hw/arts_tick.v */
`timescale 1ns/1ps
`include "arts_defines.vh"
module arts_tick #(
	parameter SYS_DIV = `ARTS_SYS_DIV,
	parameter EXT_DIV = `ARTS_EXT_DIV
) (
	input wire clk, // system clock
	input wire rst_n, // synchronised reset, active low
	input wire ext_osc, // raw external oscillator level
	output reg tick_div12_reg, // one pulse per SYS_DIV clocks
	output reg tick_ext8_reg // one pulse per EXT_DIV osc edges
);
	reg [3:0] sys_cnt_reg;
	reg [2:0] ext_cnt_reg;
	reg ext_s1_reg;
	reg ext_s2_reg;
	reg ext_s3_reg;
	wire ext_rise;

	// ****************************************
	// system clock prescaler
	// ****************************************
	// one pulse every SYS_DIV clocks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_cnt_reg <= 4'h0;
			tick_div12_reg <= 1'b0;
		end else if (sys_cnt_reg == SYS_DIV - 1) begin
			sys_cnt_reg <= 4'h0;
			tick_div12_reg <= 1'b1;
		end else begin
			sys_cnt_reg <= sys_cnt_reg + 4'h1;
			tick_div12_reg <= 1'b0;
		end
	end

	// ****************************************
	// external oscillator divide and sync
	// ****************************************
	// s1 feeds only s2; edge detect looks at s2/s3 to avoid metastability
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_osc; // RL7
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	assign ext_rise = ext_s2_reg & ~ext_s3_reg;

	// osc must be below clk/2 or edges are lost
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt_reg <= 3'h0;
			tick_ext8_reg <= 1'b0;
		end else begin
			tick_ext8_reg <= 1'b0;
			if (ext_rise) begin
				if (ext_cnt_reg == EXT_DIV - 1) begin
					ext_cnt_reg <= 3'h0;
					tick_ext8_reg <= 1'b1; // RL7
				end else begin
					ext_cnt_reg <= ext_cnt_reg + 3'h1;
				end
			end
		end
	end
endmodule

/* File: hw/arts_timer.v */
`timescale 1ns/1ps
`include "arts_defines.vh"
// Overview of operation
// RL1: 16-bit mode counts up, on 0xffff reloads and sets high overflow flag.
// RL2: 16-bit mode requests interrupt on every full overflow when enabled.
// RL3: with low-byte enable too, low byte rollover also requests interrupt.
// RL4: split mode with capture enable low runs two 8-bit reload counters.
// RL5: in split mode run bit gates high byte only; low always counts.
// RL6: per byte: select bit 1 uses clock, else clk/12 or ext/8.
// RL7: external divide-by-8 source is synchronised to the system clock.
// RL8: split mode sets high or low flag on that byte's 0xff rollover.
// RL9: split interrupt on high overflow; with low enable, on either.
// RL10: handler reads both flags to find the interrupting byte.
// RL11: flags never cleared by hardware; software writes zero to clear.
// RL12: low flag sets on any low byte 0xff rollover, either mode.
// RL13: 16-bit mode counts only while run bit set; stop holds value.
// RL14: unused control bits read zero and ignore writes.
// RL15: control at 0xc8 page f, with single bit set and clear.
// RL16: reload low 0xca, high 0xcb, read/write, reset zero.
// RL17: count low 0xcc, high 0xcd, read/write, one word or two bytes.
// RL18: capture enable is a plain input; split counting only while low.
module arts_timer (
	input wire clk, // system clock, 125 MHz
	input wire rstn, // async reset, active low
	input wire [7:0] sfr_addr, // register address
	input wire [3:0] sfr_page, // register page
	input wire sfr_wr, // byte write strobe
	input wire [7:0] sfr_wdata, // byte write data
	input wire sfr_bit_wr, // single bit write strobe
	input wire [2:0] sfr_bit_sel, // bit index for bit write
	input wire sfr_bit_val, // value for bit write
	input wire sfr_rd, // read strobe
	output reg [7:0] sfr_rdata_reg, // read data, one cycle after strobe
	input wire high_byte_clock_select, // 1: high byte on system clock
	input wire low_byte_clock_select, // 1: low byte on system clock
	input wire timer_irq_enable, // timer enable from interrupt enable reg
	input wire capture_enable, // must be 0 for split counting
	input wire ext_osc, // external oscillator level
	output reg irq_request_reg // interrupt request level
);
	reg rst_s1_reg;
	reg rst_n_reg;
	reg [7:0] ctrl_reg;
	reg [7:0] ctrl_next;
	reg [7:0] rld_lo_reg;
	reg [7:0] rld_hi_reg;
	reg [7:0] cnt_lo_reg;
	reg [7:0] cnt_hi_reg;
	reg [7:0] cnt_lo_next;
	reg [7:0] cnt_hi_next;
	reg set_high;
	reg set_low;
	reg [7:0] rd_mux;
	wire tick_div12;
	wire tick_ext8;
	wire on_page;
	wire split;
	wire run;
	wire ext_sel;
	wire tick_lo;
	wire tick_hi;
	wire inc_lo;
	wire inc_hi;
	wire wr_ctrl;
	wire bit_ctrl;
	wire irq_next;

	// ****************************************
	// reset release
	// ****************************************
	// async assert, release through two flops
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	// ****************************************
	// count sources
	// ****************************************
	// one prescaler serves both bytes so they stay in phase
	arts_tick u_tick (
		.clk(clk),
		.rst_n(rst_n_reg),
		.ext_osc(ext_osc),
		.tick_div12_reg(tick_div12),
		.tick_ext8_reg(tick_ext8)
	);

	assign split = ctrl_reg[`ARTS_BIT_SPLIT];
	assign run = ctrl_reg[`ARTS_BIT_RUN];
	assign ext_sel = ctrl_reg[`ARTS_BIT_EXT_SEL];

	// per byte source pick; 16-bit mode uses the low byte select
	assign tick_lo = low_byte_clock_select | (ext_sel ? tick_ext8 :
		tick_div12); // RL6
	assign tick_hi = high_byte_clock_select | (ext_sel ? tick_ext8 :
		tick_div12); // RL6

	// low counts free in split mode; run gates high only
	assign inc_lo = split ? (tick_lo & ~capture_enable) :
		(run & tick_lo); // RL5 RL13 RL18
	assign inc_hi = split & run & tick_hi & ~capture_enable; // RL4 RL5

	// ****************************************
	// counter next state
	// ****************************************
	// counting, reload and overflow detection
	always @* begin
		cnt_lo_next = cnt_lo_reg;
		cnt_hi_next = cnt_hi_reg;
		set_high = 1'b0;
		set_low = 1'b0;
		if (!split) begin
			if (inc_lo) begin
				if ({cnt_hi_reg, cnt_lo_reg} == `ARTS_WORD_ONES) begin
					cnt_lo_next = rld_lo_reg; // RL1
					cnt_hi_next = rld_hi_reg; // RL1
					set_high = 1'b1; // RL1
				end else begin
					{cnt_hi_next, cnt_lo_next} =
						{cnt_hi_reg, cnt_lo_reg} + 16'h0001;
				end
				if (cnt_lo_reg == `ARTS_BYTE_ONES)
					set_low = 1'b1; // RL12
			end
		end else begin
			if (inc_lo) begin
				if (cnt_lo_reg == `ARTS_BYTE_ONES) begin
					cnt_lo_next = rld_lo_reg; // RL4
					set_low = 1'b1; // RL8 RL12
				end else begin
					cnt_lo_next = cnt_lo_reg + 8'h01;
				end
			end
			if (inc_hi) begin
				if (cnt_hi_reg == `ARTS_BYTE_ONES) begin
					cnt_hi_next = rld_hi_reg; // RL4
					set_high = 1'b1; // RL8
				end else begin
					cnt_hi_next = cnt_hi_reg + 8'h01;
				end
			end
		end
	end

	// ****************************************
	// register access
	// ****************************************
	assign on_page = (sfr_page == `ARTS_PAGE);
	assign wr_ctrl = sfr_wr & on_page &
		(sfr_addr == `ARTS_ADDR_CTRL); // RL15
	assign bit_ctrl = sfr_bit_wr & on_page &
		(sfr_addr == `ARTS_ADDR_CTRL); // RL15

	// software write first, then hardware sets so an event is never lost
	always @* begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = sfr_wdata & `ARTS_CTRL_MASK; // RL14
		else if (bit_ctrl)
			ctrl_next[sfr_bit_sel] = sfr_bit_val; // RL15
		ctrl_next = ctrl_next & `ARTS_CTRL_MASK; // RL14
		if (set_high)
			ctrl_next[`ARTS_BIT_HIGH_OVF] = 1'b1; // RL11
		if (set_low)
			ctrl_next[`ARTS_BIT_LOW_OVF] = 1'b1; // RL11
	end

	// control, reload and count bytes; a software count write beats a tick
	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_reg <= `ARTS_RESET_BYTE;
			rld_lo_reg <= `ARTS_RESET_BYTE;
			rld_hi_reg <= `ARTS_RESET_BYTE;
			cnt_lo_reg <= `ARTS_RESET_BYTE;
			cnt_hi_reg <= `ARTS_RESET_BYTE;
		end else begin
			ctrl_reg <= ctrl_next;
			if (sfr_wr && on_page && sfr_addr == `ARTS_ADDR_RLD_LO)
				rld_lo_reg <= sfr_wdata; // RL16
			if (sfr_wr && on_page && sfr_addr == `ARTS_ADDR_RLD_HI)
				rld_hi_reg <= sfr_wdata; // RL16
			if (sfr_wr && on_page && sfr_addr == `ARTS_ADDR_CNT_LO)
				cnt_lo_reg <= sfr_wdata; // RL17
			else
				cnt_lo_reg <= cnt_lo_next;
			if (sfr_wr && on_page && sfr_addr == `ARTS_ADDR_CNT_HI)
				cnt_hi_reg <= sfr_wdata; // RL17
			else
				cnt_hi_reg <= cnt_hi_next;
		end
	end

	// read select; off page or unmapped reads zero
	always @* begin
		rd_mux = `ARTS_RESET_BYTE;
		if (on_page) begin
			case (sfr_addr)
			`ARTS_ADDR_CTRL: rd_mux = ctrl_reg & `ARTS_CTRL_MASK; // RL14
			`ARTS_ADDR_RLD_LO: rd_mux = rld_lo_reg; // RL16
			`ARTS_ADDR_RLD_HI: rd_mux = rld_hi_reg; // RL16
			`ARTS_ADDR_CNT_LO: rd_mux = cnt_lo_reg; // RL17
			`ARTS_ADDR_CNT_HI: rd_mux = cnt_hi_reg; // RL17
			default: rd_mux = `ARTS_RESET_BYTE;
			endcase
		end
	end

	// ****************************************
	// interrupt request
	// ****************************************
	// level follows flags, so handler must clear the high flag, and the low flag when low enable is set, to drop it
	assign irq_next = timer_irq_enable &
		(ctrl_reg[`ARTS_BIT_HIGH_OVF] | // RL2 RL9
		(ctrl_reg[`ARTS_BIT_LOW_IRQ_EN] &
		ctrl_reg[`ARTS_BIT_LOW_OVF])); // RL3 RL9 RL10

	always @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sfr_rdata_reg <= `ARTS_RESET_BYTE;
			irq_request_reg <= 1'b0;
		end else begin
			if (sfr_rd)
				sfr_rdata_reg <= rd_mux;
			irq_request_reg <= irq_next;
		end
	end
endmodule

/* File: tb/arts_osc_model.sv */
`timescale 1ns/1ps
// free-running external oscillator; a crystal does not pause between uses
module arts_osc_model #(
	parameter int HALF_NS = 12
) (
	output logic osc // oscillator level
);
	// slower than the system clock so the synchroniser never misses a level
	initial osc = 1'b0;
	always #(HALF_NS) osc = ~osc;
endmodule

/* File: tb/arts_timer_chk.sv */
`timescale 1ns/1ps
module arts_timer_chk (
	input wire clk, // system clock
	input wire rstn, // reset, active low
	input wire [7:0] sfr_addr, // address
	input wire [3:0] sfr_page, // page
	input wire sfr_wr, // byte write
	input wire [7:0] sfr_wdata, // write data
	input wire sfr_bit_wr, // bit write
	input wire [2:0] sfr_bit_sel, // bit index
	input wire sfr_bit_val, // bit value
	input wire sfr_rd, // read strobe
	input wire [7:0] sfr_rdata_reg, // read data
	input wire high_byte_clock_select, // high select
	input wire low_byte_clock_select, // low select
	input wire timer_irq_enable, // irq enable
	input wire capture_enable, // capture enable
	input wire ext_osc, // oscillator
	input wire irq_request_reg // irq level
);
	// decoded strobes shared by the properties below
	wire pf = sfr_page == 4'hf;
	wire rc = sfr_rd && pf && sfr_addr == 8'hc8;
	wire mapped = pf && (sfr_addr == 8'hc8 ||
		sfr_addr inside {[8'hca:8'hcd]});
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	rst_quiet_a: assert property (disable iff (1'b0)
		!rstn |=> !irq_request_reg && sfr_rdata_reg == 8'h00)
		else $error("outputs not quiet in reset");
	unmapped_read_a: assert property (sfr_rd && !mapped
		|=> sfr_rdata_reg == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_reg))
		else $error("read data moved without read");
	irq_gate_a: assert property (!timer_irq_enable |=> !irq_request_reg)
		else $error("irq without enable");
	irq_flags_a: assert property (rc && timer_irq_enable |=>
		irq_request_reg == (sfr_rdata_reg[7] |
		sfr_rdata_reg[5] & sfr_rdata_reg[6]))
		else $error("irq disagrees with flags");
	bit_write_a: assert property (sfr_bit_wr && !sfr_wr && pf
		&& sfr_addr == 8'hc8 && sfr_bit_sel == 3'd2 ##2 rc
		|=> sfr_rdata_reg[2] == $past(sfr_bit_val, 3))
		else $error("bit write lost");
	ctrl_write_a: assert property (sfr_wr && pf && sfr_addr == 8'hc8 ##2 rc
		|=> (sfr_rdata_reg & 8'h3f) == ($past(sfr_wdata, 3) & 8'h2d))
		else $error("control write wrong");
	reload_rb_a: assert property (sfr_wr && pf
		&& sfr_addr inside {8'hca, 8'hcb}
		##2 sfr_rd && pf && sfr_addr == $past(sfr_addr, 2)
		|=> sfr_rdata_reg == $past(sfr_wdata, 3))
		else $error("reload readback wrong");
endmodule

/* File: tb/arts_timer_tb.sv */
`timescale 1ns/1ps
module arts_timer_tb;
	logic clk = 1'b0, rstn = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, d, r0, r1;
	logic [3:0] sfr_page = 4'hf;
	logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, sfr_rd = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic high_byte_clock_select = 1'b0, low_byte_clock_select = 1'b0;
	logic timer_irq_enable = 1'b0, capture_enable = 1'b0;
	wire ext_osc, irq_request_reg;
	wire [7:0] sfr_rdata_reg;
	int miscompares = 0, total_checks = 0;
	logic [31:0] rng = 32'd93;
	arts_timer DUT (.*);
	arts_osc_model #(.HALF_NS(12)) osc_u (.osc(ext_osc));
	// 125 MHz system clock
	always #4 clk = ~clk;
	// xorshift source, fixed seed for repeatable runs
	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction
	// ticks expected in 240 clocks: oscillator period is 24 ns
	function automatic int tk(input int x);
		return x ? 240 * 8 / (8 * 24) : 240 / 12;
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic bw(input logic [2:0] s, input logic v);
		@(posedge clk);
		sfr_addr <= 8'hc8;
		sfr_bit_sel <= s;
		sfr_bit_val <= v;
		sfr_bit_wr <= 1'b1;
		@(posedge clk);
		sfr_bit_wr <= 1'b0;
	endtask
	// read data loads on the taking edge and holds; fetch it one edge later
	// so later stimulus still changes on a rising edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		d = sfr_rdata_reg;
	endtask
	// bounded wait; running out counts against the run
	task automatic wait_irq(input logic lvl, input int n);
		int i;
		for (i = 0; i < n && irq_request_reg !== lvl; i++) @(posedge clk) #1;
		if (irq_request_reg !== lvl) begin
			miscompares++;
			$display("ERROR %0t: wait ran out", $time);
			stop_test();
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		// reset values, plus the unmapped hole at c9
		for (int i = 0; i < 6; i++) begin
			rd(i == 5 ? 8'hc9 : (i == 0 ? 8'hc8 : 8'hc9 + i[7:0]));
			check(d, 8'h00);
		end
		// foreign page is refused both ways
		sfr_page <= 4'he;
		wr(8'hca, 8'h5a);
		rd(8'hca);
		check(d, 8'h00);
		sfr_page <= 4'hf;
		rd(8'hca);
		check(d, 8'h00);
		wr(8'hc8, 8'h12);
		rd(8'hc8);
		check(d, 8'h00);
		repeat (4) begin
			r0 = rnd();
			r1 = rnd();
			wr(8'hca, r0);
			rd(8'hca);
			check(d, r0);
			wr(8'hcb, r1);
			rd(8'hcb);
			check(d, r1);
		end
		// 16-bit rollover on clk/12, stopped well before the next tick
		timer_irq_enable <= 1'b1;
		wr(8'hcc, 8'hfe);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h04);
		wait_irq(1'b1, 100);
		bw(3'd2, 1'b0);
		rd(8'hc8);
		check(d, 8'hc0);
		rd(8'hcd);
		check(d, r1);
		repeat (30) @(posedge clk);
		rd(8'hcc);
		check(d, r0);
		bw(3'd7, 1'b0);
		bw(3'd6, 1'b0);
		rd(8'hc8);
		check(d, 8'h00);
		check({7'h00, irq_request_reg}, 8'h00);
		// split: low byte runs alone, high waits for run
		high_byte_clock_select <= 1'b1;
		low_byte_clock_select <= 1'b1;
		wr(8'hcd, 8'h80);
		wr(8'hcc, 8'hf0);
		wr(8'hc8, 8'h28);
		wait_irq(1'b1, 60);
		rd(8'hc8);
		check(d, 8'h68);
		rd(8'hcd);
		check(d, 8'h80);
		bw(3'd5, 1'b0);
		wait_irq(1'b0, 8);
		bw(3'd2, 1'b1);
		wait_irq(1'b1, 300);
		rd(8'hc8);
		check(d & 8'h80, 8'h80);
		// capture enable freezes split counting; release lets it run again
		capture_enable <= 1'b1;
		wr(8'hcc, 8'h33);
		repeat (20) @(posedge clk);
		rd(8'hcc);
		check(d, 8'h33);
		capture_enable <= 1'b0;
		rd(8'hcc);
		check(d, 8'h34);
		// 16-bit mode: a low byte rollover alone raises the request
		// second clear drops a flag that may have been set with the first
		wr(8'hc8, 8'h00);
		wr(8'hcd, 8'h10);
		wr(8'hcc, 8'hfd);
		wr(8'hc8, 8'h00);
		wr(8'hc8, 8'h24);
		wait_irq(1'b1, 20);
		rd(8'hc8);
		check(d, 8'h64);
		// divided sources: clk/12, then oscillator/8
		high_byte_clock_select <= 1'b0;
		low_byte_clock_select <= 1'b0;
		for (int x = 0; x < 2; x++) begin
			wr(8'hc8, 8'h00);
			wr(8'hcc, 8'h00);
			wr(8'hcd, 8'h00);
			wr(8'hc8, x ? 8'h05 : 8'h04);
			repeat (240) @(posedge clk);
			bw(3'd2, 1'b0);
			rd(8'hcc);
			check({7'h00, d >= tk(x) - 1 && d <= tk(x) + 1}, 8'h01);
		end
		stop_test();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("ERROR %0t: run too long", $time);
		stop_test();
	end
endmodule
bind arts_timer arts_timer_chk chk_u (.*);
